// ### design/pri_pkg.sv
// pri_pkg: constants and types of the peripheral register interface
// assumes a 32-bit word-only peripheral bus and a single clock domain
package pri_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int NCH_MAX = 4;
  localparam int WIN_PERIPH = 14;
  localparam int WIN_INTC = 12;
  localparam logic [31:0] BASE_RST = 32'hfffc_0000;

  // ----------------------------------------------------------------
  // register word indices, byte offset is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_MODE = 6'h01;
  localparam logic [5:0] IDX_CHEN = 6'h02;
  localparam logic [5:0] IDX_CHDIS = 6'h03;
  localparam logic [5:0] IDX_CHSR = 6'h04;
  localparam logic [5:0] IDX_STAT = 6'h05;
  localparam logic [5:0] IDX_IER = 6'h06;
  localparam logic [5:0] IDX_IDR = 6'h07;
  localparam logic [5:0] IDX_IMR = 6'h08;
  localparam logic [5:0] IDX_RDAT = 6'h09;
  localparam logic [1:0] CH_REGION = 2'h1;
  localparam logic [1:0] CH_SUB_PTR = 2'h0;
  localparam logic [1:0] CH_SUB_CNT = 2'h1;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int MODE_W = 2;
  localparam logic [MODE_W-1:0] MODE_RST = 2'h0;
  localparam int STAT_W = 6;
  localparam int ST_RXRDY = 4;
  localparam int ST_RXFULL = 5;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  typedef enum logic [1:0] {
    PRI_SZ_BYTE = 2'b00,
    PRI_SZ_HALF = 2'b01,
    PRI_SZ_WORD = 2'b10
  } pri_size_t;

endpackage

// ### design/pri_buf.sv
// pri_buf: small circular buffer with valid/ready on both sides
// assumes power-of-two depth; head data come straight from entry flops
`timescale 1ns/10ps
module pri_buf #(
  parameter int W = 32,
  parameter int DEPTH = 2
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
    $error("pri_buf: depth must be a power of two, at least 2");
  end

  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready_o = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_reg != '0;
  assign out_data_o = mem_reg[rp_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// ### design/pri_regs.sv
// pri_regs: common peripheral register interface with transfer channels
// assumes an APB-style master, word-only, one clock; channel movers pulse
// xfer_i once per completed transfer while chan_active_o is high
`timescale 1ns/10ps
module pri_regs
  import pri_pkg::*;
#(
  parameter int NUM_PORTS = 2,
  parameter int WIN_BITS = WIN_PERIPH,
  parameter logic [31:0] BASE_ADDR = BASE_RST,
  parameter int BUF_DEPTH = 2,
  localparam int NCH = 2 * NUM_PORTS
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  output logic [DATA_W-1:0] prdata_o,
  input wire logic rx_valid_i,
  input wire logic [DATA_W-1:0] rx_data_i,
  output logic rx_ready_o,
  input wire logic [NCH-1:0] xfer_i,
  output logic [NCH-1:0] chan_active_o,
  output logic [NCH*32-1:0] chan_addr_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (NUM_PORTS < 1 || NCH > NCH_MAX) begin : g_bad_ports
    $error("pri_regs: one or two serial ports only");
  end
  if (WIN_BITS != WIN_PERIPH && WIN_BITS != WIN_INTC) begin : g_bad_win
    $error("pri_regs: window must be 16 or 4 Kbyte");
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic in_win;
  logic mapped;
  logic [5:0] off;
  logic wr_en;
  logic rd_setup;
  logic rd_acc;
  logic ch_hit;
  logic [1:0] ch_sel;
  logic [1:0] ch_sub;

  assign in_win = psel_i && (paddr_i[31:WIN_BITS] == BASE_ADDR[31:WIN_BITS]);
  assign mapped = paddr_i[WIN_BITS-1:8] == '0;
  // bits 1:0 never decoded, so narrow accesses land on the word
  assign off = paddr_i[7:2];
  assign wr_en = in_win && mapped && penable_i && pwrite_i;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  assign rd_acc = in_win && mapped && penable_i && !pwrite_i;
  assign ch_hit = off[5:4] == CH_REGION && 32'(off[3:2]) < NCH;
  assign ch_sel = off[3:2];
  assign ch_sub = off[1:0];

  // ----------------------------------------------------------------
  // mode, channel run state, mask
  // ----------------------------------------------------------------
  logic [MODE_W-1:0] mode_reg;
  logic [NCH-1:0] chsr_reg;
  logic [STAT_W-1:0] mask_reg;
  logic [NCH-1:0] end_reg;
  logic [NCH-1:0] end_set;
  logic [STAT_W-1:0] stat_w;
  logic [31:0] step;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= MODE_RST;
    end else if (wr_en && off == IDX_MODE) begin
      mode_reg <= pwdata_i[MODE_W-1:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chsr_reg <= '0;
    end else if (wr_en && off == IDX_CHEN) begin
      chsr_reg <= chsr_reg | pwdata_i[NCH-1:0];
    end else if (wr_en && off == IDX_CHDIS) begin
      chsr_reg <= chsr_reg & ~pwdata_i[NCH-1:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_reg <= '0;
    end else if (wr_en && off == IDX_IER) begin
      mask_reg <= mask_reg | pwdata_i[STAT_W-1:0];
    end else if (wr_en && off == IDX_IDR) begin
      mask_reg <= mask_reg & ~pwdata_i[STAT_W-1:0];
    end
  end

  // control bits clear end flags; a completion in the same cycle wins
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      end_reg <= '0;
    end else if (wr_en && off == IDX_CTRL) begin
      end_reg <= (end_reg & ~pwdata_i[NCH-1:0]) | end_set;
    end else begin
      end_reg <= end_reg | end_set;
    end
  end

  always_comb begin
    case (mode_reg)
      PRI_SZ_BYTE: step = 32'h0000_0001;
      PRI_SZ_HALF: step = 32'h0000_0002;
      default: step = 32'h0000_0004;
    endcase
  end

  // ----------------------------------------------------------------
  // receive buffer
  // ----------------------------------------------------------------
  logic buf_valid;
  logic buf_in_ready;
  logic [DATA_W-1:0] buf_data;
  logic buf_pop;

  assign buf_pop = rd_acc && off == IDX_RDAT;
  assign rx_ready_o = buf_in_ready;

  pri_buf #(
    .W(DATA_W),
    .DEPTH(BUF_DEPTH)
  ) u_rx_buf (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(rx_valid_i),
    .in_data_i(rx_data_i),
    .in_ready_o(buf_in_ready),
    .out_valid_o(buf_valid),
    .out_data_o(buf_data),
    .out_ready_i(buf_pop)
  );

  // status is built from hardware state; control writes clear end flags and receive data reads pop the buffer
  always_comb begin
    stat_w = '0;
    stat_w[NCH-1:0] = end_reg;
    stat_w[ST_RXRDY] = buf_valid;
    stat_w[ST_RXFULL] = !buf_in_ready;
  end

  assign irq_o = |(stat_w & mask_reg);

  // ----------------------------------------------------------------
  // transfer channels, index 2p is rx and 2p+1 is tx of port p
  // ----------------------------------------------------------------
  logic [31:0] ptr_w [NCH];
  logic [CNT_W-1:0] cnt_w [NCH];

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [31:0] ptr_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic wr_p;
    logic wr_c;
    logic step_ok;

    assign wr_p = wr_en && ch_hit && ch_sel == 2'(c) && ch_sub == CH_SUB_PTR;
    assign wr_c = wr_en && ch_hit && ch_sel == 2'(c) && ch_sub == CH_SUB_CNT;
    assign step_ok = xfer_i[c] && chsr_reg[c] && cnt_reg != '0;

    // a software write overrides a transfer in the same cycle
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        ptr_reg <= '0;
      end else if (wr_p) begin
        ptr_reg <= pwdata_i;
      end else if (step_ok) begin
        ptr_reg <= ptr_reg + step;
      end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cnt_reg <= '0;
      end else if (wr_c) begin
        cnt_reg <= pwdata_i[CNT_W-1:0];
      end else if (step_ok) begin
        cnt_reg <= cnt_reg - CNT_ONE;
      end
    end

    assign end_set[c] = step_ok && !wr_c && cnt_reg == CNT_ONE;
    assign chan_active_o[c] = chsr_reg[c] && cnt_reg != '0;
    assign chan_addr_o[c*32 +: 32] = ptr_reg;
    assign ptr_w[c] = ptr_reg;
    assign cnt_w[c] = cnt_reg;
  end

  // ----------------------------------------------------------------
  // read path, captured in setup so data stand through access
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_next;

  always_comb begin
    rd_next = '0;
    if (ch_hit) begin
      if (ch_sub == CH_SUB_PTR) begin
        rd_next = ptr_w[ch_sel];
      end else if (ch_sub == CH_SUB_CNT) begin
        rd_next[CNT_W-1:0] = cnt_w[ch_sel];
      end
    end else begin
      case (off)
        IDX_MODE: rd_next[MODE_W-1:0] = mode_reg;
        IDX_CHSR: rd_next[NCH-1:0] = chsr_reg;
        IDX_STAT: rd_next[STAT_W-1:0] = stat_w;
        IDX_IMR: rd_next[STAT_W-1:0] = mask_reg;
        IDX_RDAT: rd_next = buf_valid ? buf_data : '0;
        default: rd_next = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= '0;
    end else if (rd_setup) begin
      // refused reads return zero rather than a stale word
      prdata_o <= (in_win && mapped) ? rd_next : '0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  property p_word_access;
    wr_en && off == IDX_MODE |=> mode_reg == $past(pwdata_i[MODE_W-1:0]);
  endproperty
  a_word_access: assert property (p_word_access) else $error("mode write missed");

  property p_window;
    psel_i && penable_i && pwrite_i && !in_win |=> $stable(mode_reg) && $stable(mask_reg);
  endproperty
  a_window: assert property (p_window) else $error("write outside window took effect");

  property p_ctrl_clear;
    wr_en && off == IDX_CTRL && end_set == '0 |=> (end_reg & $past(pwdata_i[NCH-1:0])) == '0;
  endproperty
  a_ctrl_clear: assert property (p_ctrl_clear) else $error("end flag not cleared");

  property p_chen;
    wr_en && off == IDX_CHEN |=> (chsr_reg & $past(pwdata_i[NCH-1:0])) == $past(pwdata_i[NCH-1:0]);
  endproperty
  a_chen: assert property (p_chen) else $error("enable did not set");

  property p_chdis;
    wr_en && off == IDX_CHDIS |=> (chsr_reg & $past(pwdata_i[NCH-1:0])) == '0;
  endproperty
  a_chdis: assert property (p_chdis) else $error("disable not visible");

  property p_unused_zero;
    rd_setup && off == IDX_MODE |=> prdata_o[DATA_W-1:MODE_W] == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero");

  property p_irq;
    (stat_w & mask_reg) != '0 |-> irq_o ##0 (mask_reg != '0);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_ier;
    wr_en && off == IDX_IER |=> (mask_reg | $past(mask_reg)) == mask_reg && !$fell(irq_o);
  endproperty
  a_ier: assert property (p_ier) else $error("mask enable lost bits");

  property p_end_flag;
    end_set[0] |=> end_reg[0] && !chan_active_o[0];
  endproperty
  a_end_flag: assert property (p_end_flag) else $error("end flag not set");

  property p_count_step;
    xfer_i[0] && chan_active_o[0] && !(wr_en && ch_hit) |=>
      cnt_w[0] == $past(cnt_w[0]) - CNT_ONE && ptr_w[0] == $past(ptr_w[0]) + $past(step);
  endproperty
  a_count_step: assert property (p_count_step) else $error("channel step wrong");

  c_end_irq: cover property (end_set[0] ##1 irq_o);
  c_buf_full: cover property (!rx_ready_o ##1 buf_pop);
  c_chan_done: cover property (chan_active_o[1] ##[1:50] !chan_active_o[1]);

endmodule

// ### tb/pri_host.sv
// pri_host: bus master model for the register port
// assumes no wait states; every transfer is a setup then an access cycle
`timescale 1ns/10ps
module pri_host (
  input wire logic mclk_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [31:0] paddr_o,
  output logic [31:0] pwdata_o
);
  // ----------------------------------------------------------------
  // transfer
  // ----------------------------------------------------------------
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 32'h0;
    pwdata_o = 32'h0;
  end

  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge mclk_i);
    penable_o <= 1'b1;
    @(posedge mclk_i);
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // released lines show the inverse so stale values never match
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
endmodule

// ### tb/tb.sv
// tb: self-checking bench of the peripheral register interface
// assumes default parameters: two ports, four channels, 16-Kbyte window
`timescale 1ns/10ps
module tb;
  import pri_pkg::*;
  logic mclk_i, rst_n_i, psel, penable, pwrite, rx_valid, rx_ready, irq;
  logic [31:0] paddr, pwdata, prdata, rx_data, v, p, w1, w2, w3;
  logic [3:0] xfer, active;
  logic [127:0] caddr;
  logic [31:0] q[$];
  int errors, checked, cycles, step;

  pri_host u_host(.mclk_i(mclk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));
  pri_regs DUT(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready), .xfer_i(xfer),
    .chan_active_o(active), .chan_addr_o(caddr), .irq_o(irq));

  // ----------------------------------------------------------------
  // clock, timeout, checking
  // ----------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test;
    end
  end

  // read data stands in the access phase; oldest note is the match
  always @(posedge mclk_i) begin
    if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0) chk(prdata, q.pop_front());
  end

  function automatic logic [31:0] ra(input logic [7:0] off);
    return BASE_RST + {24'h0, off};
  endfunction

  task wr(input logic [31:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d);
  endtask

  task rd(input logic [31:0] a, input logic [31:0] e);
    q.push_back(e);
    u_host.xfer(1'b0, a, ~e);
  endtask

  // no bound here: the cycle ceiling cuts a stuck buffer short
  task rx_push(input logic [31:0] d);
    @(posedge mclk_i);
    rx_valid <= 1'b1;
    rx_data <= d;
    do @(posedge mclk_i); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    rx_data <= ~d;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    rx_valid = 1'b0;
    rx_data = 32'h0;
    xfer = 4'h0;
    v = $urandom(85);
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(ra(8'h04), 32'h0);
    rd(ra(8'h10), 32'h0);
    rd(ra(8'h20), 32'h0);
    @(negedge mclk_i);
    chk({26'h0, active, irq, rx_ready}, 32'h1);
    $display("reset test done");

    // nonzero mode so a refused read cannot pass on stale data
    v = $urandom | 32'h1;
    wr(ra(8'h06), {30'h0, v[1:0]});
    wr(ra(8'h14), 32'h0000_003f);
    rd(ra(8'h14), 32'h0);
    rd(ra(8'h00), 32'h0);
    wr(BASE_RST + 32'h0000_4004, {30'h0, ~v[1:0]});
    wr(ra(8'h00) + 32'h0000_0104, {30'h0, ~v[1:0]});
    rd(ra(8'h07), {30'h0, v[1:0]});
    rd(BASE_RST + 32'h0000_4004, 32'h0);
    rd(ra(8'h04), {30'h0, v[1:0]});
    rd(ra(8'h00) + 32'h0000_0104, 32'h0);
    $display("access test done");

    wr(ra(8'h08), 32'h5);
    wr(ra(8'h08), 32'h2);
    rd(ra(8'h10), 32'h7);
    wr(ra(8'h0c), 32'h9);
    rd(ra(8'h10), 32'h6);
    wr(ra(8'h0c), 32'hf);
    rd(ra(8'h10), 32'h0);
    $display("shadow test done");

    w1 = $urandom;
    w2 = $urandom;
    w3 = $urandom;
    wr(ra(8'h18), 32'h10);
    rd(ra(8'h20), 32'h10);
    rx_push(w1);
    rx_push(w2);
    @(negedge mclk_i);
    chk({30'h0, irq, rx_ready}, 32'h2);
    rd(ra(8'h14), 32'h30);
    wr(ra(8'h1c), 32'h10);
    @(negedge mclk_i);
    chk({31'h0, irq}, 32'h0);
    fork
      rx_push(w3);
      rd(ra(8'h24), w1);
    join
    rd(ra(8'h24), w2);
    rd(ra(8'h24), w3);
    rd(ra(8'h24), 32'h0);
    rd(ra(8'h14), 32'h0);
    $display("buffer test done");

    wr(ra(8'h18), 32'hf);
    for (int c = 0; c < 4; c++) begin
      step = (c == 0) ? 1 : (c == 1) ? 2 : 4;
      p = $urandom;
      wr(ra(8'h04), c);
      wr(ra(8'h40 + 8'(16 * c)), p);
      wr(ra(8'h44 + 8'(16 * c)), 32'h2);
      rd(ra(8'h44 + 8'(16 * c)), 32'h2);
      wr(ra(8'h08), 32'h1 << c);
      // third back-to-back pulse lands on an idle channel
      @(posedge mclk_i);
      xfer <= 4'(1 << c);
      repeat (3) @(posedge mclk_i);
      xfer <= 4'h0;
      @(negedge mclk_i);
      chk(caddr[32 * c +: 32], p + 32'(2 * step));
      rd(ra(8'h40 + 8'(16 * c)), p + 32'(2 * step));
      chk({27'h0, active, irq}, 32'h1);
      rd(ra(8'h44 + 8'(16 * c)), 32'h0);
      rd(ra(8'h14), 32'h1 << c);
      wr(ra(8'h00), 32'h1 << c);
      rd(ra(8'h14), 32'h0);
      wr(ra(8'h0c), 32'h1 << c);
    end
    $display("channel test done");
    end_of_test;
  end
endmodule
